/* pkg/fslc_pkg.sv */
// Purpose: Constants shared by the fuse section and lock configuration block.
// Assumes: Fuse bytes are presented as stable levels from the fuse array.
// Notes:   Times are in microseconds; cycle counts derive from the core clock rate.
package fslc_pkg;
    localparam int unsigned CORE_CLK_HZ     = 40_000_000;
    localparam logic [7:0]  OFS_STARTUP     = 8'h06;
    localparam logic [7:0]  OFS_APP_END     = 8'h07;
    localparam logic [7:0]  OFS_BOOT_END    = 8'h08;
    localparam logic [7:0]  OFS_LOCK_KEY    = 8'h0A;
    localparam logic [7:0]  UNLOCK_KEY      = 8'hC5;
    localparam logic [7:0]  SECTION_NONE    = 8'h00;
    localparam int unsigned BLOCK_SHIFT     = 8;
    localparam int unsigned BLOCK_BYTES     = 256;
    localparam int unsigned STARTUP_MSB     = 2;
    localparam int unsigned STARTUP_LSB     = 0;
    localparam logic [7:0]  STARTUP_RST     = 8'h07;
    localparam logic [7:0]  APP_END_RST     = 8'h00;
    localparam logic [7:0]  BOOT_END_RST    = 8'h00;
    localparam logic [7:0]  LOCK_KEY_RST    = 8'h00;
    localparam int unsigned MS_US           = 1000;
    localparam int unsigned UNIT_DELAY_US   = 1000;
    localparam int unsigned UNIT_DELAY_CYC  = (CORE_CLK_HZ / 1_000_000) * UNIT_DELAY_US;
    localparam int unsigned MAX_DELAY_SHIFT = 6;
    localparam int unsigned MAX_DELAY_CYC   = UNIT_DELAY_CYC << MAX_DELAY_SHIFT;

    typedef enum logic [1:0]
    {
        FSLC_REGION_BOOT = 2'b00,
        FSLC_REGION_CODE = 2'b01,
        FSLC_REGION_DATA = 2'b10
    } fslc_region_t;
endpackage : fslc_pkg

/* core/fslc_delay_timer.sv */
// Purpose: Start-up hold-off timer counting core clock cycles.
// Assumes: The target count is stable from the cycle i_start rises.
// Notes:   A zero target releases on the cycle after start.
`timescale 1ns/1ps
module fslc_delay_timer
    import fslc_pkg::*;
#(
    parameter int unsigned CNT_W = 32
)
(
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    input  wire logic             i_start,
    input  wire logic [CNT_W-1:0] i_target,
    output logic                  o_done
);
    logic [CNT_W-1:0] cnt_q;
    logic             done_q;
    wire              hit = (cnt_q >= i_target);

    // The counter runs only until the target is reached so it cannot wrap.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end
        else if (i_start && !done_q)
        begin
            if (hit)
                done_q <= 1'b1;
            else
                cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    assign o_done = done_q;
endmodule : fslc_delay_timer

/* core/fslc_config.sv */
// Purpose: Decode fuse bytes into start-up delay, flash sections and lock state.
// Assumes: Fuse inputs come from a fuse array that is static while powered.
// Notes:   Fuses are captured once on the first clock after reset release.
//          Decodes load on the second clock; o_fuses_valid marks that point and
//          starts the start-up counter, so the counter never sees a stale target.
//          A lock key write is only forwarded to the fuse programmer; the lock
//          state follows the key captured at reset, so a new key acts after reset.
//          The hold-off for code 7 takes 2,560,000 core clocks at 40 MHz, so the
//          counter width must not drop below 22 bits.
//          Section end outputs are zero, so every address reads as data, and the part is locked until fuses load.
//          Debug requests are refused until the decodes have loaded.
`timescale 1ns/1ps
module fslc_config
    import fslc_pkg::*;
#(
    parameter int unsigned ADDR_W     = 16,
    parameter int unsigned FLASH_SIZE = 16384,
    parameter int unsigned CNT_W      = 32
)
(
    input  wire logic               i_core_clk,
    input  wire logic               i_rst,
    input  wire logic [7:0]         i_fuse_startup,
    input  wire logic [7:0]         i_fuse_app_end,
    input  wire logic [7:0]         i_fuse_boot_end,
    input  wire logic [7:0]         i_fuse_lock_key,
    input  wire logic [7:0]         i_fuse_addr,
    input  wire logic               i_fuse_wr,
    input  wire logic [7:0]         i_fuse_wdata,
    input  wire logic [ADDR_W-1:0]  i_flash_addr,
    input  wire logic               i_dbg_req,
    input  wire logic               i_dbg_is_info,
    output logic [7:0]              o_fuse_rdata,
    output logic                    o_fuse_lock_wr,
    output logic [7:0]              o_fuse_lock_wdata,
    output logic [ADDR_W-1:0]       o_boot_end_addr,
    output logic [ADDR_W-1:0]       o_code_end_addr,
    output fslc_region_t            o_flash_region,
    output logic                    o_locked,
    output logic                    o_dbg_grant,
    output logic                    o_cpu_release,
    output logic                    o_fuses_valid
);
    // Fuse bytes as captured on the first clock after reset.
    logic [7:0]        startup_q;
    logic [7:0]        app_end_q;
    logic [7:0]        boot_end_q;
    logic [7:0]        lock_key_q;
    logic              valid_q;

    // Decoded results, loaded once on the second clock.
    logic              loaded_q;
    logic              locked_q;
    logic [ADDR_W-1:0] boot_bound_q;
    logic [ADDR_W-1:0] code_end_q;
    logic [CNT_W-1:0]  target_q;

    // Register port read data.
    logic [7:0]        rdata_q;

    // Delay in cycles for a start-up code: zero, then one ms doubled per step.
    // A shift keeps the table out of logic; the widest step is the 64 ms code.
    function automatic logic [CNT_W-1:0] startup_cycles(input logic [2:0] code);
        logic [CNT_W-1:0] base;
        base = CNT_W'(UNIT_DELAY_CYC);
        if (code == 3'h0)
            startup_cycles = '0;
        else
            startup_cycles = base << (code - 3'h1);
    endfunction : startup_cycles

    // Section fuses count 256-byte blocks; bits above the address width drop off.
    function automatic logic [ADDR_W-1:0] block_to_addr(input logic [7:0] blocks);
        logic [ADDR_W+7:0] wide;
        wide          = {{ADDR_W{1'b0}}, blocks} << BLOCK_SHIFT;
        block_to_addr = wide[ADDR_W-1:0];
    endfunction : block_to_addr

    // Fuse offset match, shared by the read mux and the write filter.
    function automatic logic offset_hit(input logic [7:0] addr, input logic [7:0] ofs);
        offset_hit = (addr == ofs);
    endfunction : offset_hit

    // Fuse capture happens once so a later fuse write cannot move boundaries.
    // The fuse array is static while powered, so no synchroniser is placed here.
    // Capture runs on the first clock after reset, before any decode is used.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            startup_q  <= STARTUP_RST;
            app_end_q  <= APP_END_RST;
            boot_end_q <= BOOT_END_RST;
            lock_key_q <= LOCK_KEY_RST;
            valid_q    <= 1'b0;
        end
        else if (!valid_q)
        begin
            startup_q  <= i_fuse_startup;
            app_end_q  <= i_fuse_app_end;
            boot_end_q <= i_fuse_boot_end;
            lock_key_q <= i_fuse_lock_key;
            valid_q    <= 1'b1;
        end
    end

    // Boundary arithmetic from the captured fuses.
    // Ends are exclusive: an address equal to an end belongs to the next section.
    wire [ADDR_W-1:0] flash_top  = ADDR_W'(FLASH_SIZE);
    wire [ADDR_W-1:0] boot_raw   = block_to_addr(boot_end_q);
    wire [ADDR_W-1:0] app_raw    = block_to_addr(app_end_q);
    wire              boot_zero  = (boot_end_q == SECTION_NONE);
    wire              app_zero   = (app_end_q == SECTION_NONE);
    // A zero boot fuse with a defined code end still splits at the code end.
    wire [ADDR_W-1:0] boot_end_d = boot_zero ? (app_zero ? flash_top : app_raw) : boot_raw;
    wire [ADDR_W-1:0] code_end_d = app_zero ? flash_top : app_raw;
    wire              key_ok     = (lock_key_q == UNLOCK_KEY);

    // Decoded values held stable until the next reset.
    // Reset leaves the part locked and the longest delay loaded, the safe side.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            boot_bound_q <= '0;
            code_end_q   <= '0;
            locked_q     <= 1'b1;
            target_q     <= CNT_W'(MAX_DELAY_CYC);
        end
        else if (valid_q && !loaded_q)
        begin
            boot_bound_q <= boot_end_d;
            code_end_q   <= code_end_d;
            locked_q     <= !key_ok;
            target_q     <= startup_cycles(startup_q[STARTUP_MSB:STARTUP_LSB]);
        end
    end

    // Second-stage flag marks decodes as loaded.
    // It rises one clock after capture, together with the decoded values.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            loaded_q <= 1'b0;
        else if (valid_q)
            loaded_q <= 1'b1;
    end

    // Timer is started only once decodes are loaded, else it sees a stale target.
    // A reset in mid-count restarts the full hold-off from the new fuse values.
    fslc_delay_timer #(
        .CNT_W      (CNT_W)
    ) u_timer (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_start    (loaded_q),
        .i_target   (target_q),
        .o_done     (o_cpu_release)
    );

    // Region classification of a flash address.
    // The boot test comes first, so an empty code section needs no special case.
    // Before the decodes load, both ends are zero and every address reads as data.
    wire in_boot = (i_flash_addr < boot_bound_q);
    wire in_code = (i_flash_addr < code_end_q);
    assign o_flash_region = in_boot ? FSLC_REGION_BOOT :
                            in_code ? FSLC_REGION_CODE : FSLC_REGION_DATA;

    // Debug access gate; locked state allows info block reads only.
    // Requests before the decodes load are refused, since the lock state is not known yet.
    assign o_dbg_grant = i_dbg_req && loaded_q && (!locked_q || i_dbg_is_info);

    // Fuse read mux; unmapped offsets read as zero.
    // The start-up byte shows only its three defined bits; the rest read as zero.
    wire [7:0] rdata_d = offset_hit(i_fuse_addr, OFS_STARTUP)  ? {5'h00, startup_q[STARTUP_MSB:STARTUP_LSB]} :
                         offset_hit(i_fuse_addr, OFS_APP_END)  ? app_end_q :
                         offset_hit(i_fuse_addr, OFS_BOOT_END) ? boot_end_q :
                         offset_hit(i_fuse_addr, OFS_LOCK_KEY) ? lock_key_q : 8'h00;
    // Only the lock key offset forwards a write to the fuse programmer.
    // Writes to the other offsets are dropped without any error indication.
    wire lock_wr_d = i_fuse_wr && offset_hit(i_fuse_addr, OFS_LOCK_KEY);
    logic       lock_wr_q;
    logic [7:0] lock_wdata_q;

    // Registered read data and write forward.
    // Read data lags the address by one clock; write data is held after the pulse.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rdata_q      <= 8'h00;
            lock_wr_q    <= 1'b0;
            lock_wdata_q <= 8'h00;
        end
        else
        begin
            rdata_q      <= rdata_d;
            lock_wr_q    <= lock_wr_d;
            lock_wdata_q <= lock_wr_d ? i_fuse_wdata : lock_wdata_q;
        end
    end

    // Data outputs come straight from flip-flops; only region and grant are decodes.
    assign o_fuse_rdata      = rdata_q;
    assign o_fuse_lock_wr    = lock_wr_q;
    assign o_fuse_lock_wdata = lock_wdata_q;
    assign o_boot_end_addr   = boot_bound_q;
    assign o_code_end_addr   = code_end_q;
    assign o_locked          = locked_q;
    assign o_fuses_valid     = loaded_q;
endmodule : fslc_config

/* dv/fslc_config_props.sv */
// Purpose: Port assertions for the fuse section and lock block.
// Assumes: Fuse inputs move only while reset is high.
// Notes:   Bound into the block top; all checks rest during reset.
`timescale 1ns/1ps
module fslc_config_props
    import fslc_pkg::*;
#(
    parameter int unsigned ADDR_W = 16
)
(
    input wire logic              i_core_clk,
    input wire logic              i_rst,
    input wire logic [7:0]        i_fuse_app_end,
    input wire logic [7:0]        i_fuse_lock_key,
    input wire logic [7:0]        i_fuse_addr,
    input wire logic              i_fuse_wr,
    input wire logic [7:0]        i_fuse_wdata,
    input wire logic [ADDR_W-1:0] i_flash_addr,
    input wire logic              i_dbg_req,
    input wire logic              i_dbg_is_info,
    input wire logic              o_fuse_lock_wr,
    input wire logic [7:0]        o_fuse_lock_wdata,
    input wire logic [ADDR_W-1:0] o_code_end_addr,
    input wire fslc_region_t      o_flash_region,
    input wire logic              o_locked,
    input wire logic              o_dbg_grant,
    input wire logic              o_cpu_release,
    input wire logic              o_fuses_valid
);
    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Decodes must follow the fuse bytes once loaded.
    property p_key; o_fuses_valid |-> o_locked == (i_fuse_lock_key != 8'hC5); endproperty
    a_key: assert property (p_key) else $error("lock state disagrees with key");
    property p_grant; o_dbg_grant == (i_dbg_req && o_fuses_valid && (!o_locked || i_dbg_is_info)); endproperty
    a_grant: assert property (p_grant) else $error("debug grant wrong");
    property p_cend; o_fuses_valid && i_fuse_app_end != 8'h00 |-> o_code_end_addr == {i_fuse_app_end, 8'h00}; endproperty
    a_cend: assert property (p_cend) else $error("code end wrong");
    property p_data; o_fuses_valid && i_fuse_app_end != 8'h00 && i_flash_addr >= {i_fuse_app_end, 8'h00}
        |-> o_flash_region == FSLC_REGION_DATA; endproperty
    a_data: assert property (p_data) else $error("data region wrong");
    // Only the lock byte accepts writes; a write pulses one cycle later.
    property p_lwr; i_fuse_wr && i_fuse_addr == 8'h0A |=> o_fuse_lock_wr && o_fuse_lock_wdata == $past(i_fuse_wdata); endproperty
    a_lwr: assert property (p_lwr) else $error("lock write missing");
    property p_ro; i_fuse_wr && i_fuse_addr != 8'h0A |=> !o_fuse_lock_wr; endproperty
    a_ro: assert property (p_ro) else $error("read-only byte written");
    property p_hold; o_fuses_valid |=> $stable(o_code_end_addr) && $stable(o_locked); endproperty
    a_hold: assert property (p_hold) else $error("decode moved");
    property p_rel; o_cpu_release |=> o_cpu_release; endproperty
    a_rel: assert property (p_rel) else $error("release dropped");
endmodule : fslc_config_props

bind fslc_config fslc_config_props #(.ADDR_W(ADDR_W)) i_props (.*);

/* dv/test_fslc_config.sv */
// Purpose: Self-checking bench for the fuse section and lock block.
// Assumes: Fuses change only while reset is held.
// Notes:   Only short start-up codes are timed; 64 ms would take millions of cycles.
`timescale 1ns/1ps
module test_fslc_config;
    import fslc_pkg::*;
    logic         i_core_clk = 1'b0;
    logic         i_rst = 1'b1;
    logic [7:0]   fs = 8'h00, fa = 8'h00, fb = 8'h00, fk = 8'h00, addr = 8'h00, wd = 8'h00;
    logic         wr = 1'b0, req = 1'b0, info = 1'b0;
    logic [15:0]  fla = 16'h0000, bend, cend;
    logic [7:0]   rdata, lwd;
    logic         lwr, locked, grant, rel, valid;
    fslc_region_t region;
    int           fail_count = 0;
    int           checks_done = 0;
    // Core clock at 40 MHz.
    always #12.5 i_core_clk = ~i_core_clk;
    fslc_config i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_fuse_startup(fs), .i_fuse_app_end(fa),
        .i_fuse_boot_end(fb), .i_fuse_lock_key(fk), .i_fuse_addr(addr), .i_fuse_wr(wr), .i_fuse_wdata(wd),
        .i_flash_addr(fla), .i_dbg_req(req), .i_dbg_is_info(info), .o_fuse_rdata(rdata), .o_fuse_lock_wr(lwr),
        .o_fuse_lock_wdata(lwd), .o_boot_end_addr(bend), .o_code_end_addr(cend), .o_flash_region(region),
        .o_locked(locked), .o_dbg_grant(grant), .o_cpu_release(rel), .o_fuses_valid(valid));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        if (fail_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    // Fuses only matter at reset, so each setting gets a fresh reset.
    task automatic boot(input logic [7:0] s, input logic [7:0] a, input logic [7:0] b, input logic [7:0] k);
        int n;
        @(negedge i_core_clk);
        {i_rst, fs, fa, fb, fk} = {1'b1, s, a, b, k};
        repeat (12) @(negedge i_core_clk);
        i_rst = 1'b0;
        for (n = 0; n < 8 && valid !== 1'b1; n++) @(negedge i_core_clk);
        if (valid !== 1'b1)
        begin
            fail_count++;
            conclude();
        end
    endtask : boot
    task automatic reg_at(input logic [15:0] a, input logic [15:0] exp);
        @(negedge i_core_clk);
        fla = a;
        #1 chk(16'(region), exp);
    endtask : reg_at
    task automatic s_sections();
        boot(8'h00, 8'h20, 8'h10, 8'hC5);
        chk(bend, 16'h1000);
        chk(cend, 16'h2000);
        reg_at(16'h0FFF, 16'(FSLC_REGION_BOOT));
        reg_at(16'h1000, 16'(FSLC_REGION_CODE));
        reg_at(16'h1FFF, 16'(FSLC_REGION_CODE));
        reg_at(16'h2000, 16'(FSLC_REGION_DATA));
        boot(8'h00, 8'h00, 8'h10, 8'hC5);
        chk(cend, 16'h4000);
        reg_at(16'h0FFF, 16'(FSLC_REGION_BOOT));
        reg_at(16'h3FFF, 16'(FSLC_REGION_CODE));
        boot(8'h00, 8'h20, 8'h00, 8'hC5);
        reg_at(16'h0000, 16'(FSLC_REGION_BOOT));
        reg_at(16'h1FFF, 16'(FSLC_REGION_BOOT));
        reg_at(16'h2000, 16'(FSLC_REGION_DATA));
        boot(8'h00, 8'h00, 8'h00, 8'hC5);
        reg_at(16'h3FFF, 16'(FSLC_REGION_BOOT));
    endtask : s_sections
    task automatic s_lock();
        logic [7:0] keys [4] = '{8'hC5, 8'hC4, 8'h45, 8'h00};
        foreach (keys[i])
        begin
            boot(8'h00, 8'h00, 8'h00, keys[i]);
            chk(16'(locked), 16'(keys[i] != 8'hC5));
            {req, info} = 2'b10;
            #1 chk(16'(grant), 16'(keys[i] == 8'hC5));
            @(negedge i_core_clk);
            info = 1'b1;
            #1 chk(16'(grant), 16'h0001);
            @(negedge i_core_clk);
            req = 1'b0;
            #1 chk(16'(grant), 16'h0000);
        end
    endtask : s_lock
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        @(negedge i_core_clk);
        chk(16'(rdata), 16'(exp));
    endtask : rd
    // Writes aim at a read-only byte, then at the lock byte.
    task automatic s_regs();
        boot(8'hF9, 8'h21, 8'h12, 8'h3C);
        rd(8'h06, 8'h01);
        rd(8'h07, 8'h21);
        rd(8'h08, 8'h12);
        rd(8'h0A, 8'h3C);
        rd(8'h09, 8'h00);
        {addr, wd, wr} = {8'h07, 8'hAA, 1'b1};
        @(negedge i_core_clk);
        {addr, wd} = {8'h0A, 8'h5A};
        chk(16'(lwr), 16'h0000);
        @(negedge i_core_clk);
        wr = 1'b0;
        chk(16'(lwr), 16'h0001);
        chk(16'(lwd), 16'h005A);
        rd(8'h07, 8'h21);
        chk(16'(lwr), 16'h0000);
        rd(8'h0A, 8'h3C);
        chk(16'(locked), 16'h0001);
    endtask : s_regs
    task automatic s_delay();
        int n;
        boot(8'h00, 8'h00, 8'h00, 8'hC5);
        for (n = 0; n < 4 && rel !== 1'b1; n++) @(negedge i_core_clk);
        chk(16'(rel), 16'h0001);
        boot(8'h01, 8'h00, 8'h00, 8'hC5);
        repeat (39900) @(negedge i_core_clk);
        chk(16'(rel), 16'h0000);
        for (n = 0; n < 200 && rel !== 1'b1; n++) @(negedge i_core_clk);
        chk(16'(rel), 16'h0001);
        boot(8'h02, 8'h00, 8'h00, 8'hC5);
        repeat (40100) @(negedge i_core_clk);
        chk(16'(rel), 16'h0000);
    endtask : s_delay
    // Main sequence.
    initial
    begin
        s_sections();
        s_lock();
        s_regs();
        s_delay();
        conclude();
    end
endmodule : test_fslc_config
